// file: hdl/srcdet_pkg.sv
package srcdet_pkg;
  localparam int CLK_HZ = 10_000_000;
  // times in ms
  localparam int DCD_ON_MS = 40;
  localparam int DCD_WAIT_MS = 500;
  localparam int PRI_MS = 40;
  localparam int RETRY_MS = 2000;
  localparam int INTERNAL_REGULATOR_DLY_MS = 220;
  localparam int BOOST_DLY_MS = 220;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int DCD_ON_CYC = DCD_ON_MS * CYC_PER_MS;
  localparam int DCD_WAIT_CYC = DCD_WAIT_MS * CYC_PER_MS;
  localparam int PRI_CYC = PRI_MS * CYC_PER_MS;
  localparam int RETRY_CYC = RETRY_MS * CYC_PER_MS;
  localparam int INTERNAL_REGULATOR_DLY_CYC = INTERNAL_REGULATOR_DLY_MS * CYC_PER_MS;
  localparam int BOOST_DLY_CYC = BOOST_DLY_MS * CYC_PER_MS;
  localparam int TMR_W = 25;
  // register map, byte addresses
  localparam logic [3:0] ADR_INCTL = 4'h0;
  localparam logic [3:0] ADR_CHGCFG = 4'h4;
  localparam logic [3:0] ADR_MISC = 4'h8;
  localparam logic [3:0] ADR_STAT = 4'hc;
  // input control, charge config and misc fields
  localparam int HIZ_BIT = 7;
  localparam int VLIM_LSB = 3;
  localparam int EXTERNAL_LIMIT_PIN_LSB = 0;
  localparam int CHGCFG_LSB = 4;
  localparam int MINSYS_LSB = 1;
  localparam int FORCE_BIT = 7;
  localparam int BSWOFF_BIT = 5;
  localparam int HOSTMODE_BIT = 0;
  // status fields
  localparam int VBUS_LSB = 6;
  localparam int DPM_BIT = 3;
  localparam int PG_BIT = 2;
  localparam int MINSYS_STAT_BIT = 0;
  // reset values
  localparam logic [7:0] INCTL_RST = 8'h30;
  localparam logic [7:0] CHGCFG_RST = 8'h1b;
  localparam logic [7:0] MISC_RST = 8'h00;
  // input limit and charge mode codes
  localparam logic [2:0] EXTERNAL_LIMIT_PIN_100 = 3'h0;
  localparam logic [2:0] EXTERNAL_LIMIT_PIN_500 = 3'h2;
  localparam logic [2:0] EXTERNAL_LIMIT_PIN_1500 = 3'h5;
  localparam logic [1:0] CHG_BOOST = 2'h2;
  localparam logic [1:0] CHG_OFF = 2'h0;
  // input type codes
  localparam logic [1:0] TYP_NONE = 2'h0;
  localparam logic [1:0] TYP_HOST = 2'h1;
  localparam logic [1:0] TYP_CHGPORT = 2'h2;
  localparam logic [1:0] TYP_BOOST = 2'h3;

  typedef struct packed {
    logic dp_isrc;
    logic dm_pulldown;
    logic dp_vsrc;
    logic dm_isink;
  } usb_drv_s;

  typedef struct packed {
    logic below_ovp;
    logic above_poor;
    logic above_uvlo;
    logic sleep_ok;
    logic bat_good;
    logic bat_low_ok;
    logic bat_depleted;
    logic sys_above_2v2;
    logic sys_below_bat;
    logic sys_at_min;
    logic iin_over;
    logic vin_under;
  } analog_s;
endpackage : srcdet_pkg

// file: hdl/input_source_detect_power_path.sv
// Operation
// - qualify source: below 18V, above 3.8V loaded
// - qualified source sets power-good, raises interrupt
// - poor source retried every 2 seconds
// - detect on attach unless host-mode high-impedance
// - contact detect: D+ source, D- pulldown 40ms
// - wait up to 0.5s D+ low, release
// - primary detect 40ms: D- low host, high port
// - results set limit and input-type code
// - 100mA host, good battery: high-impedance state
// - host mode: high-impedance until host clears
// - default mode: removal clears high-impedance, redetect
// - force-detect bit self-clears after detection
// - limit set enables converter; switch per charging
// - rail below 2.2V forces 100mA, else minimum
// - boost after 220ms when all conditions hold
// - boost mode reports input type 11
// - minimum system voltage three-bit field, default 3.5V
// - status bit while held at minimum voltage
// - overload reduces charge current until limits met
// - dynamic power management bit while regulating
// - supplement mode on rail below battery
// - regulator needs uvlo, sleep and 220ms delay
//
// The Wishbone register port and the register addresses are this design's own decisions.
module input_source_detect_power_path #(
  parameter int MS_CYC = srcdet_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // wishbone slave
  input wire logic I_CYC,
  input wire logic I_STB,
  input wire logic I_WE,
  input wire logic [3:0] I_ADR,
  input wire logic [3:0] I_SEL,
  input wire logic [31:0] I_DAT,
  output logic [31:0] O_DAT,
  output logic O_ACK,
  // analog comparators and pins
  input wire srcdet_pkg::analog_s I_ANA,
  input wire logic I_VBUS_PRESENT,
  input wire logic I_DPLUS,
  input wire logic I_DMINUS,
  input wire logic I_BOOST_REQUEST_PIN,
  input wire logic [2:0] I_EXTERNAL_LIMIT_PIN,
  // controls to analog
  output srcdet_pkg::usb_drv_s O_USB_DRV,
  output logic O_POOR_LOAD,
  output logic O_INTERNAL_REGULATOR,
  output logic O_CONVERTER_EN,
  output logic O_BATTERY_SWITCH,
  output logic O_BOOST_EN,
  output logic O_REDUCE_CHARGE,
  output logic [2:0] O_EXTERNAL_LIMIT_PIN_EFF,
  output logic [3:0] O_VLIM,
  output logic [2:0] O_MINSYS,
  output logic O_INT
);
  import srcdet_pkg::*;

  // cycle counts follow the clock rate handed in
  localparam int INTERNAL_REGULATOR_N = INTERNAL_REGULATOR_DLY_MS * MS_CYC;
  localparam int RETRY_N = RETRY_MS * MS_CYC;
  localparam int DCD_ON_N = DCD_ON_MS * MS_CYC;
  localparam int DCD_WAIT_N = DCD_WAIT_MS * MS_CYC;
  localparam int PRI_N = PRI_MS * MS_CYC;
  localparam int BOOST_N = BOOST_DLY_MS * MS_CYC;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_INTERNAL_REGULATOR = 8'h02, S_QUAL = 8'h04, S_RETRY = 8'h08,
    S_DCD = 8'h10, S_DCDW = 8'h20, S_PRI = 8'h40, S_RUN = 8'h80
  } st_e;

  st_e st_r;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] btmr_r;
  analog_s ana_m, ana_r;
  logic [4:0] pin_m, pin_r;
  logic [2:0] ext_m, ext_r;
  logic [7:0] inctl_r, chgcfg_r, misc_r;
  logic pg_r, dpm_r, minsys_r, boost_r, supp_r, int_r;
  logic [1:0] typ_r;
  logic vbus_d_r, sys_ok_r;
  logic [2:0] det_lim_r;
  logic det_done;
  logic attach, remove;
  logic wr, rd_stb;
  logic [7:0] stat;

  // two-flop synchronisers on every analog and pin input
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ana_m <= '0;
      ana_r <= '0;
      pin_m <= '0;
      pin_r <= '0;
      ext_m <= '0;
      ext_r <= '0;
    end else begin
      ext_m <= I_EXTERNAL_LIMIT_PIN;
      ext_r <= ext_m;
      ana_m <= I_ANA;
      ana_r <= ana_m;
      pin_m <= {I_VBUS_PRESENT, I_DPLUS, I_DMINUS, I_BOOST_REQUEST_PIN, 1'b0};
      pin_r <= pin_m;
    end
  end

  wire vbus = pin_r[4];
  wire dp = pin_r[3];
  wire dm = pin_r[2];
  wire boost_request_pin = pin_r[1];
  wire host_mode = misc_r[HOSTMODE_BIT];
  wire high_impedance_state = inctl_r[HIZ_BIT];

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      vbus_d_r <= 1'b0;
    else
      vbus_d_r <= vbus;
  end
  assign attach = vbus && !vbus_d_r;
  assign remove = !vbus && vbus_d_r;

  // wishbone: one wait state, ack drops after one cycle
  assign wr = I_CYC && I_STB && I_WE && !O_ACK;
  assign rd_stb = I_CYC && I_STB && !O_ACK;
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      O_ACK <= 1'b0;
    else
      O_ACK <= rd_stb;
  end

  assign stat = {typ_r, 2'b00, dpm_r, pg_r, 1'b0, minsys_r};

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      O_DAT <= '0;
    else if (rd_stb) begin
      unique case (I_ADR)
        ADR_INCTL: O_DAT <= {24'h0, inctl_r};
        ADR_CHGCFG: O_DAT <= {24'h0, chgcfg_r};
        ADR_MISC: O_DAT <= {24'h0, misc_r};
        ADR_STAT: O_DAT <= {24'h0, stat};
        default: O_DAT <= '0;
      endcase
    end
  end

  // input control: high-impedance, voltage and current limits
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      inctl_r <= INCTL_RST;
    else begin
      if (wr && I_SEL[0] && I_ADR == ADR_INCTL)
        inctl_r <= I_DAT[7:0];
      if (det_done) begin
        inctl_r[2:0] <= det_lim_r;
        if (det_lim_r == EXTERNAL_LIMIT_PIN_100 && typ_r == TYP_HOST && ana_r.bat_good)
          inctl_r[HIZ_BIT] <= 1'b1;
      end
      // hardware set of high-impedance wins over software write
      if (remove && !host_mode)
        inctl_r[HIZ_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      chgcfg_r <= CHGCFG_RST;
    else if (wr && I_SEL[0] && I_ADR == ADR_CHGCFG)
      chgcfg_r <= I_DAT[7:0];
  end

  // force-detect: self clear after completion; a software write in the same cycle wins
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      misc_r <= MISC_RST;
    else if (wr && I_SEL[0] && I_ADR == ADR_MISC)
      misc_r <= I_DAT[7:0];
    else if (det_done)
      misc_r[FORCE_BIT] <= 1'b0;
  end

  assign O_VLIM = inctl_r[6:3];
  assign O_MINSYS = chgcfg_r[3:1];

  // attach sequence
  wire force_det = misc_r[FORCE_BIT] && st_r == S_RUN;
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_r <= S_IDLE;
      tmr_r <= '0;
    end else if (!vbus || attach) begin
      st_r <= S_IDLE;
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_r + 1'b1;
      unique case (st_r)
        S_IDLE: begin
          st_r <= S_INTERNAL_REGULATOR;
          tmr_r <= '0;
        end
        S_INTERNAL_REGULATOR: begin
          if (!(ana_r.above_uvlo && ana_r.sleep_ok) || (high_impedance_state && host_mode))
            tmr_r <= '0;
          else if (tmr_r >= TMR_W'(INTERNAL_REGULATOR_N - 1)) begin
            st_r <= S_QUAL;
            tmr_r <= '0;
          end
        end
        S_QUAL: if (tmr_r >= TMR_W'(MS_CYC - 1)) begin
          tmr_r <= '0;
          if (ana_r.below_ovp && ana_r.above_poor)
            st_r <= S_DCD;
          else
            st_r <= S_RETRY;
        end
        S_RETRY: if (tmr_r >= TMR_W'(RETRY_N - 1)) begin
          st_r <= S_QUAL;
          tmr_r <= '0;
        end
        S_DCD: if (tmr_r >= TMR_W'(DCD_ON_N - 1)) begin
          st_r <= S_DCDW;
          tmr_r <= '0;
        end
        S_DCDW: if (!dp || tmr_r >= TMR_W'(DCD_WAIT_N - 1)) begin
          st_r <= dp ? S_RUN : S_PRI;
          tmr_r <= '0;
        end
        S_PRI: if (tmr_r >= TMR_W'(PRI_N - 1)) begin
          st_r <= S_RUN;
          tmr_r <= '0;
        end
        S_RUN: if (force_det) begin
          st_r <= S_DCD;
          tmr_r <= '0;
        end
      endcase
    end
  end

  assign det_done = vbus && !attach && ((st_r == S_DCDW && dp &&
    tmr_r >= TMR_W'(DCD_WAIT_N - 1)) ||
    (st_r == S_PRI && tmr_r >= TMR_W'(PRI_N - 1)));

  // detection result capture
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      det_lim_r <= EXTERNAL_LIMIT_PIN_100;
      typ_r <= TYP_NONE;
    end else if (boost_r)
      typ_r <= TYP_BOOST;
    else if (st_r == S_DCDW && dp && tmr_r >= TMR_W'(DCD_WAIT_N - 2)) begin
      det_lim_r <= EXTERNAL_LIMIT_PIN_100;
      typ_r <= TYP_NONE;
    end else if (st_r == S_PRI) begin
      if (dm) begin
        det_lim_r <= EXTERNAL_LIMIT_PIN_1500;
        typ_r <= TYP_CHGPORT;
      end else begin
        det_lim_r <= boost_request_pin ? EXTERNAL_LIMIT_PIN_500 : EXTERNAL_LIMIT_PIN_100;
        typ_r <= TYP_HOST;
      end
    end else if (typ_r == TYP_BOOST)
      typ_r <= TYP_NONE;
  end

  // power-good and interrupt pulse
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pg_r <= 1'b0;
      int_r <= 1'b0;
    end else begin
      int_r <= 1'b0;
      if (!vbus)
        pg_r <= 1'b0;
      else if (st_r == S_QUAL && tmr_r >= TMR_W'(MS_CYC - 1) &&
               ana_r.below_ovp && ana_r.above_poor && !pg_r) begin
        pg_r <= 1'b1;
        int_r <= 1'b1;
      end
    end
  end
  assign O_INT = int_r;

  assign O_USB_DRV.dp_isrc = st_r == S_DCD || st_r == S_DCDW;
  assign O_USB_DRV.dm_pulldown = st_r == S_DCD || st_r == S_DCDW;
  assign O_USB_DRV.dp_vsrc = st_r == S_PRI;
  assign O_USB_DRV.dm_isink = st_r == S_PRI;
  assign O_POOR_LOAD = st_r == S_QUAL;
  assign O_INTERNAL_REGULATOR = !(st_r == S_IDLE || st_r == S_INTERNAL_REGULATOR) &&
    !high_impedance_state;

  // converter and battery switch
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sys_ok_r <= 1'b0;
      O_CONVERTER_EN <= 1'b0;
    end else begin
      sys_ok_r <= ana_r.sys_above_2v2;
      O_CONVERTER_EN <= st_r == S_RUN && !high_impedance_state;
    end
  end

  // limit is the lower of register and pin; soft-start clamp
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      O_EXTERNAL_LIMIT_PIN_EFF <= EXTERNAL_LIMIT_PIN_100;
    else if (!sys_ok_r)
      O_EXTERNAL_LIMIT_PIN_EFF <= EXTERNAL_LIMIT_PIN_100;
    else if (inctl_r[2:0] < ext_r)
      O_EXTERNAL_LIMIT_PIN_EFF <= inctl_r[2:0];
    else
      O_EXTERNAL_LIMIT_PIN_EFF <= ext_r;
  end

  // supplement mode
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      supp_r <= 1'b0;
    else if (ana_r.bat_depleted)
      supp_r <= 1'b0;
    else if (ana_r.sys_below_bat)
      supp_r <= 1'b1;
  end

  wire chg_on = chgcfg_r[5:4] != CHG_OFF && !misc_r[BSWOFF_BIT];
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      O_BATTERY_SWITCH <= 1'b0;
    else
      O_BATTERY_SWITCH <= supp_r || boost_r ||
        (O_CONVERTER_EN && chg_on);
  end

  // dynamic power management and status bits
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      dpm_r <= 1'b0;
      minsys_r <= 1'b0;
      O_REDUCE_CHARGE <= 1'b0;
    end else begin
      dpm_r <= ana_r.iin_over || ana_r.vin_under;
      O_REDUCE_CHARGE <= ana_r.iin_over || ana_r.vin_under;
      minsys_r <= ana_r.sys_at_min;
    end
  end

  // boost enable after its conditions hold continuously
  wire boost_ok = ana_r.bat_low_ok && ana_r.sleep_ok && boost_request_pin &&
    chgcfg_r[5:4] == CHG_BOOST;
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      btmr_r <= '0;
      boost_r <= 1'b0;
    end else if (!boost_ok) begin
      btmr_r <= '0;
      boost_r <= 1'b0;
    end else if (btmr_r >= TMR_W'(BOOST_N - 1))
      boost_r <= 1'b1;
    else
      btmr_r <= btmr_r + 1'b1;
  end
  assign O_BOOST_EN = boost_r;

  // checks
  property p_pg_int;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    $rose(pg_r) |-> int_r;
  endproperty
  a_pg_int: assert property (p_pg_int) else $error("pg without int");

  property p_force_clr;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    det_done && !(wr && I_ADR == ADR_MISC) |=> !misc_r[FORCE_BIT];
  endproperty
  a_force_clr: assert property (p_force_clr) else $error("force stuck");

  property p_softstart;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    !sys_ok_r |=> O_EXTERNAL_LIMIT_PIN_EFF == EXTERNAL_LIMIT_PIN_100;
  endproperty
  a_softstart: assert property (p_softstart) else $error("clamp lost");

  property p_boost_cond;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    boost_r |-> $past(boost_ok);
  endproperty
  a_boost_cond: assert property (p_boost_cond) else $error("bad boost");

  property p_boost_typ;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    boost_r |=> typ_r == TYP_BOOST;
  endproperty
  a_boost_typ: assert property (p_boost_typ) else $error("boost type");

  property p_dpm;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    ana_r.iin_over |=> dpm_r && O_REDUCE_CHARGE;
  endproperty
  a_dpm: assert property (p_dpm) else $error("dpm missing");

  property p_pri_drive;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    st_r == S_PRI |-> O_USB_DRV.dp_vsrc && !O_USB_DRV.dp_isrc;
  endproperty
  a_pri_drive: assert property (p_pri_drive) else $error("pri drive");

  property p_deplete;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
    ana_r.bat_depleted |=> !supp_r;
  endproperty
  a_deplete: assert property (p_deplete) else $error("supp stuck");
endmodule : input_source_detect_power_path

// file: verif/usb_far_side.sv
module usb_far_side (
  // device drive and far-side type
  input wire srcdet_pkg::usb_drv_s i_drv,
  input wire logic i_chg_port,
  // data lines
  output logic o_dplus,
  output logic o_dminus
);
  timeunit 1ns;
  timeprecision 1ns;
  import srcdet_pkg::*;

  // attached far side sinks the contact current, so D+ reads low then
  always_comb begin
    o_dplus = i_drv.dp_vsrc;
    // a charging port shorts D+ to D-; a host only holds its pull-down
    o_dminus = i_chg_port & i_drv.dp_vsrc & i_drv.dm_isink;
  end
endmodule : usb_far_side

// file: verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import srcdet_pkg::*;
  // ten cycles per ms keeps the run short
  localparam int MSC = 10;
  localparam int DCD_N = DCD_ON_MS * MSC;
  localparam int PRI_N = PRI_MS * MSC;
  localparam int INTERNAL_REGULATOR_N = INTERNAL_REGULATOR_DLY_MS * MSC;
  localparam int BOOST_N = BOOST_DLY_MS * MSC;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  analog_s ana = '0;
  logic vbus = 1'b0;
  logic bpin = 1'b0;
  logic [2:0] ext = 3'h7;
  logic port_kind = 1'b1;
  usb_drv_s drv;
  logic dp, dm, int_p, regon, conv, bsw, boost, redchg;
  logic [2:0] external_limit_pin, minsys;
  logic [3:0] vlim;
  logic [31:0] q;
  int bad_count = 0;
  int samples_checked = 0;
  int n;

  always #50 clk = ~clk;

  input_source_detect_power_path #(.MS_CYC(MSC)) DUT (
    .I_REF_CLK(clk), .I_RST_N(rst_n),
    .I_CYC(cyc), .I_STB(stb), .I_WE(we), .I_ADR(adr), .I_SEL(sel),
    .I_DAT(wdat), .O_DAT(rdat), .O_ACK(ack),
    .I_ANA(ana), .I_VBUS_PRESENT(vbus), .I_DPLUS(dp), .I_DMINUS(dm),
    .I_BOOST_REQUEST_PIN(bpin), .I_EXTERNAL_LIMIT_PIN(ext),
    .O_USB_DRV(drv), .O_POOR_LOAD(), .O_INTERNAL_REGULATOR(regon),
    .O_CONVERTER_EN(conv), .O_BATTERY_SWITCH(bsw), .O_BOOST_EN(boost),
    .O_REDUCE_CHARGE(redchg), .O_EXTERNAL_LIMIT_PIN_EFF(external_limit_pin), .O_VLIM(vlim),
    .O_MINSYS(minsys), .O_INT(int_p)
  );

  usb_far_side far_side (.i_drv(drv), .i_chg_port(port_kind),
    .o_dplus(dp), .o_dminus(dm));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [7:0] d, input logic s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= {3'h0, s};
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // upper bits are always compared, they must read zero
  task automatic rd(input string nm, input logic [3:0] a,
                    input logic [7:0] m, exp);
    wb(1'b0, a, 8'h00, 1'b1);
    chk(nm, q & {24'hff_ffff, m}, {24'h0, exp});
  endtask : rd

  function automatic logic sig(input int k);
    case (k)
      0: return int_p;
      1: return drv.dp_isrc;
      2: return drv.dp_vsrc;
      3: return regon;
      default: return boost;
    endcase
  endfunction : sig

  // counts edges until the level shows; the watchdog bounds a hang
  task automatic wt(input int k, input logic lvl);
    n = 0;
    while (sig(k) !== lvl) begin
      @(posedge clk);
      n++;
    end
  endtask : wt

  // slack of 8 covers the input synchronisers
  task automatic detect();
    wt(1, 1'b1);
    wt(1, 1'b0);
    chk("dcd_len", n >= DCD_N && n <= DCD_N + 8, 1);
    wt(2, 1'b1);
    wt(2, 1'b0);
    chk("pri_len", n >= PRI_N && n <= PRI_N + 8, 1);
    repeat (8) @(posedge clk);
  endtask : detect

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd("inctl", ADR_INCTL, 8'hff, INCTL_RST);
    rd("chgcfg", ADR_CHGCFG, 8'hff, CHGCFG_RST);
    rd("misc", ADR_MISC, 8'hff, MISC_RST);
    rd("unmapped", 4'h2, 8'hff, 8'h00);
    chk("vlim_rst", vlim, 32'h6);
    chk("minsys_rst", minsys, 32'h5);
    wb(1'b1, ADR_CHGCFG, 8'h17, 1'b1);
    repeat (2) @(posedge clk);
    chk("minsys_set", minsys, 32'h3);
    wb(1'b1, ADR_CHGCFG, CHGCFG_RST, 1'b1);
    wb(1'b1, ADR_INCTL, 8'hff, 1'b0);
    rd("sel_off", ADR_INCTL, 8'hff, INCTL_RST);
    ana.below_ovp <= 1'b1;
    ana.above_poor <= 1'b1;
    ana.above_uvlo <= 1'b1;
    ana.sleep_ok <= 1'b1;
    ana.bat_low_ok <= 1'b1;
    ana.sys_above_2v2 <= 1'b1;
    vbus <= 1'b1;
    wt(3, 1'b1);
    chk("reg_dly", n >= INTERNAL_REGULATOR_N && n <= INTERNAL_REGULATOR_N + 8, 1);
    wt(0, 1'b1);
    detect();
    rd("pg", ADR_STAT, 8'h04, 8'h04);
    rd("type_port", ADR_STAT, 8'hc0, {TYP_CHGPORT, 6'h0});
    chk("external_limit_pin_port", external_limit_pin, EXTERNAL_LIMIT_PIN_1500);
    chk("conv_on", {conv, bsw}, 32'h3);
    ext <= 3'h2;
    repeat (4) @(posedge clk);
    chk("external_limit_pin_pin", external_limit_pin, EXTERNAL_LIMIT_PIN_500);
    ana.sys_above_2v2 <= 1'b0;
    repeat (5) @(posedge clk);
    chk("external_limit_pin_soft", external_limit_pin, EXTERNAL_LIMIT_PIN_100);
    ana.sys_above_2v2 <= 1'b1;
    ext <= 3'h7;
    wb(1'b1, ADR_INCTL, 8'h31, 1'b1);
    repeat (4) @(posedge clk);
    chk("external_limit_pin_sw", external_limit_pin, 32'h1);
    ana.iin_over <= 1'b1;
    ana.sys_at_min <= 1'b1;
    repeat (4) @(posedge clk);
    rd("dpm_i", ADR_STAT, 8'h09, 8'h09);
    chk("reduce_i", redchg, 32'h1);
    ana.iin_over <= 1'b0;
    ana.sys_at_min <= 1'b0;
    ana.vin_under <= 1'b1;
    repeat (4) @(posedge clk);
    rd("dpm_v", ADR_STAT, 8'h09, 8'h08);
    chk("reduce_v", redchg, 32'h1);
    ana.vin_under <= 1'b0;
    repeat (4) @(posedge clk);
    rd("dpm_off", ADR_STAT, 8'h09, 8'h00);
    chk("reduce_off", redchg, 32'h0);
    port_kind <= 1'b0;
    bpin <= 1'b1;
    wb(1'b1, ADR_MISC, 8'h80, 1'b1);
    detect();
    rd("force_clr", ADR_MISC, 8'h80, 8'h00);
    rd("type_host", ADR_STAT, 8'hc0, {TYP_HOST, 6'h0});
    chk("external_limit_pin_host", external_limit_pin, EXTERNAL_LIMIT_PIN_500);
    vbus <= 1'b0;
    wb(1'b1, ADR_CHGCFG, 8'h2b, 1'b1);
    wt(4, 1'b1);
    chk("boost_dly", n + 8 >= BOOST_N && n <= BOOST_N + 16, 1);
    rd("type_boost", ADR_STAT, 8'hc0, {TYP_BOOST, 6'h0});
    test_done();
  end

  // whole run is near 6100 cycles at the shortened rate
  initial begin
    #2_000_000;
    bad_count++;
    test_done();
  end
endmodule : testbench
